// >>> verilog/dual_byte_tristate_register.sv
// Two independent 8-bit edge-triggered storage halves with three-state outputs.
`timescale 1ns/10ps
`default_nettype none
module dual_byte_tristate_register
  import dual_reg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic power_good,
  input wire logic low_half_clock,
  input wire logic high_half_clock,
  input wire logic low_half_output_enable_n,
  input wire logic high_half_output_enable_n,
  input wire logic [dual_reg_pkg::FULL_W-1:0] data_in,
  input wire logic [dual_reg_pkg::FULL_W-1:0] data_in_driven,
  output logic [dual_reg_pkg::FULL_W-1:0] data_out,
  output logic [dual_reg_pkg::FULL_W-1:0] data_out_en
);
  import dual_reg_pkg::*;

  // Pin clocks are sampled as ordinary inputs; an edge is acted on at the first clock edge that sees the pin high.
  logic [1:0] clk_prev_ff, nxt_clk_prev;
  logic [FULL_W-1:0] hold_ff, nxt_hold;
  logic [FULL_W-1:0] store_ff, nxt_store;
  logic [FULL_W-1:0] out_ff, nxt_out;
  logic [FULL_W-1:0] oe_ff, nxt_oe;
  logic low_rise;
  logic high_rise;

  // A pin edge is a high sample that follows a low one.
  function automatic logic pin_rise(input logic now_level, input logic last_level);
    pin_rise = now_level & ~last_level;
  endfunction

  function automatic logic [FULL_W-1:0] keep(input logic [FULL_W-1:0] d,
                                             input logic [FULL_W-1:0] drv,
                                             input logic [FULL_W-1:0] last);
    keep = (d & drv) | (last & ~drv);
  endfunction

  // Both halves turn one active-low pin into eight bit enables the same way.
  function automatic logic [HALF_W-1:0] half_enable(input logic enable_n);
    half_enable = {HALF_W{~enable_n}};
  endfunction

  // Pin clock sampler. A pin already high when reset ends looks like an edge.
  always_comb begin
    nxt_clk_prev = {high_half_clock, low_half_clock};
    low_rise = pin_rise(low_half_clock, clk_prev_ff[0]);
    high_rise = pin_rise(high_half_clock, clk_prev_ff[1]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_prev_ff <= {2{EDGE_RST}};
    end else if (clk_en) begin
      clk_prev_ff <= nxt_clk_prev;
    end
  end

  // The keeper holds the level an input last saw driven, so capture never sees a float.
  always_comb begin
    nxt_hold = keep(data_in, data_in_driven, hold_ff);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff <= {2{HOLD_RST}};
    end else if (clk_en) begin
      hold_ff <= nxt_hold;
    end
  end

  // Each half loads on its own pin edge only; the enables are deliberately not read here.
  always_comb begin
    nxt_store = store_ff;
    if (low_rise) begin
      nxt_store[HALF_W-1:0] = nxt_hold[HALF_W-1:0];
    end
    if (high_rise) begin
      nxt_store[FULL_W-1:HALF_W] = nxt_hold[FULL_W-1:HALF_W];
    end
    // The pin copy loads with the store, so the outputs come straight from a flip-flop.
    nxt_out = nxt_store;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_ff <= {2{STORE_RST}};
      out_ff <= {2{STORE_RST}};
    end else if (clk_en) begin
      store_ff <= nxt_store;
      out_ff <= nxt_out;
    end
  end

  // Enables are registered, so the drivers switch one cycle after the enable pins.
  always_comb begin
    nxt_oe[FULL_W-1:HALF_W] = half_enable(high_half_output_enable_n);
    nxt_oe[HALF_W-1:0] = half_enable(low_half_output_enable_n);
    // Loss of supply overrides both pins, so the drivers turn off on the first enabled clock edge after power_good falls.
    if (!power_good) begin
      nxt_oe = {FULL_W{OE_OFF}};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_ff <= {FULL_W{OE_OFF}};
    end else if (clk_en) begin
      oe_ff <= nxt_oe;
    end
  end

  assign data_out = out_ff;
  assign data_out_en = oe_ff;

  property p_low_capture;
    @(posedge clk) disable iff (rst)
      (clk_en && low_half_clock && !clk_prev_ff[0] && (&data_in_driven[7:0]))
      |=> (data_out[7:0] == $past(data_in[7:0]));
  endproperty
  a_low_capture: assert property (p_low_capture) else $error("low half missed capture");

  property p_high_capture;
    @(posedge clk) disable iff (rst)
      (clk_en && high_half_clock && !clk_prev_ff[1] && (&data_in_driven[15:8]))
      |=> (data_out[15:8] == $past(data_in[15:8]));
  endproperty
  a_high_capture: assert property (p_high_capture) else $error("high half missed capture");

  property p_enable;
    @(posedge clk) disable iff (rst)
      (clk_en && power_good) |=> (data_out_en[7:0] == {8{!$past(low_half_output_enable_n)}})
        && (data_out_en[15:8] == {8{!$past(high_half_output_enable_n)}});
  endproperty
  a_enable: assert property (p_enable) else $error("enable mismatch");

  property p_oe_no_storage;
    @(posedge clk) disable iff (rst)
      (clk_en && low_half_clock && !clk_prev_ff[0] && low_half_output_enable_n
        && data_in_driven[0]) |=> (data_out[0] == $past(data_in[0]));
  endproperty
  a_oe_no_storage: assert property (p_oe_no_storage) else $error("capture blocked by enable");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (clk_en && !(low_half_clock && !clk_prev_ff[0])) |=> $stable(data_out[7:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed without edge");

  property p_keeper;
    @(posedge clk) disable iff (rst)
      (clk_en && !data_in_driven[3] && low_half_clock && !clk_prev_ff[0])
      |=> (data_out[3] == $past(hold_ff[3]));
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper level lost");

  property p_unpowered;
    @(posedge clk) disable iff (rst)
      (clk_en && !power_good) |=> (data_out_en == 16'h0000);
  endproperty
  a_unpowered: assert property (p_unpowered) else $error("drive while unpowered");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !clk_en |=> ($stable(data_out) && $stable(data_out_en));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // The high half carries its own copies of the low half hold, enable-off capture and keeper checks, so a swapped slice shows.
  property p_high_hold;
    @(posedge clk) disable iff (rst)
      (clk_en && !(high_half_clock && !clk_prev_ff[1]))
      |=> $stable(data_out[FULL_W-1:HALF_W]);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high half moved without edge");

  property p_high_oe_keep;
    @(posedge clk) disable iff (rst)
      (clk_en && high_half_clock && !clk_prev_ff[1] && high_half_output_enable_n
        && data_in_driven[FULL_W-1]) |=> (data_out[FULL_W-1] == $past(data_in[FULL_W-1]));
  endproperty
  a_high_oe_keep: assert property (p_high_oe_keep) else $error("high capture blocked");

  property p_keeper_high;
    @(posedge clk) disable iff (rst)
      (clk_en && !data_in_driven[FULL_W-1] && high_half_clock && !clk_prev_ff[1])
      |=> (data_out[FULL_W-1] == $past(hold_ff[FULL_W-1]));
  endproperty
  a_keeper_high: assert property (p_keeper_high) else $error("high keeper level lost");

  // A low half edge alone must leave the high half untouched.
  property p_low_only;
    @(posedge clk) disable iff (rst)
      (clk_en && low_half_clock && !clk_prev_ff[0] && !(high_half_clock && !clk_prev_ff[1]))
      |=> $stable(data_out[FULL_W-1:HALF_W]);
  endproperty
  a_low_only: assert property (p_low_only) else $error("high half followed low edge");

  property p_all_off;
    @(posedge clk) disable iff (rst)
      (clk_en && low_half_output_enable_n && high_half_output_enable_n)
      |=> (data_out_en == {FULL_W{OE_OFF}});
  endproperty
  a_all_off: assert property (p_all_off) else $error("drive with both enables high");

  property p_low_on;
    @(posedge clk) disable iff (rst)
      (clk_en && power_good && !low_half_output_enable_n) |=> (&data_out_en[HALF_W-1:0]);
  endproperty
  a_low_on: assert property (p_low_on) else $error("low half not driving");
endmodule
`default_nettype wire

// >>> verilog/dual_reg_pkg.sv
// Constants shared by the dual byte three-state register.
package dual_reg_pkg;
  localparam int HALF_W = 8;
  localparam int FULL_W = 16;
  localparam logic [HALF_W-1:0] STORE_RST = 8'h00;
  localparam logic [HALF_W-1:0] HOLD_RST = 8'h00;
  localparam logic EDGE_RST = 1'b0;
  localparam logic OE_OFF = 1'b0;
endpackage

// >>> verif/bus_side.sv
// Model of the shared bus lines at the register's outputs.
`timescale 1ns/10ps
`default_nettype none
module bus_side
  import dual_reg_pkg::*;
(
  input wire logic clk,
  input wire logic [dual_reg_pkg::FULL_W-1:0] drv,
  input wire logic [dual_reg_pkg::FULL_W-1:0] drv_en,
  output logic [dual_reg_pkg::FULL_W-1:0] bus
);
  logic [FULL_W-1:0] last_ff = 16'h0000;
  // A released line has no pull, so it shows a changing level and never a stale value.
  always @(posedge clk) last_ff <= bus;
  assign bus = (drv & drv_en) | (~last_ff & ~drv_en);
endmodule
`default_nettype wire

// >>> verif/dual_byte_tristate_register_test.sv
// Self-checking bench for the dual byte three-state register.
`timescale 1ns/10ps
`default_nettype none
module dual_byte_tristate_register_test;
  import dual_reg_pkg::*;
  logic clk = 0, rst = 1, clk_en = 1, power_good = 1;
  logic low_half_clock = 0, high_half_clock = 0;
  logic low_half_output_enable_n = 1, high_half_output_enable_n = 1;
  logic [FULL_W-1:0] data_in = 16'h0000, data_in_driven = 16'hffff;
  logic [FULL_W-1:0] data_out, data_out_en, bus;
  int miscompares = 0, n_compared = 0, cycles = 0;
  always #4 clk = ~clk;
  dual_byte_tristate_register dut_u (.clk, .rst, .clk_en, .power_good, .low_half_clock,
    .high_half_clock, .low_half_output_enable_n, .high_half_output_enable_n, .data_in,
    .data_in_driven, .data_out, .data_out_en);
  bus_side side_u (.clk, .drv(data_out), .drv_en(data_out_en), .bus);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pin clocks stay high one cycle and low at least two cycles before the next step raises them, as slow as the sampler needs.
  task automatic step(input logic lo, input logic hi, input logic [15:0] d);
    @(posedge clk) #1;
    {low_half_clock, high_half_clock, data_in} = {lo, hi, d};
    @(posedge clk) #1;
    {low_half_clock, high_half_clock} = 2'b00;
    @(posedge clk) #1;
  endtask
  task automatic t_halves;
    step(1, 0, 16'h5aa5);
    chk(data_out, 16'h00a5);
    step(1, 1, 16'h3c96);
    chk(data_out, 16'h3c96);
  endtask
  task automatic t_hiz;
    step(1, 1, 16'h1234);
    chk(data_out_en, 16'h0000);
    {low_half_output_enable_n, high_half_output_enable_n} = 2'b00;
    @(posedge clk) #1;
    chk(data_out_en, 16'hffff);
    chk(bus, 16'h1234);
    high_half_output_enable_n = 1;
    @(posedge clk) #1;
    chk(data_out_en, 16'h00ff);
  endtask
  task automatic t_hold;
    data_in = 16'hffff;
    repeat (3) @(posedge clk);
    #1 chk(data_out, 16'h1234);
    // Hold the low pin clock high after one edge; later data must not get in.
    low_half_clock = 1;
    @(posedge clk) #1 data_in = 16'hff00;
    repeat (3) @(posedge clk);
    #1 chk(data_out, 16'h12ff);
    low_half_clock = 0;
  endtask
  task automatic t_keep;
    data_in_driven = 16'h00f7;
    step(1, 1, 16'h557f);
    chk(data_out, 16'hff77);
    data_in_driven = 16'hffff;
  endtask
  // Pin edges and enable changes are ignored while the clock enable is low.
  task automatic t_freeze;
    {clk_en, low_half_output_enable_n} = 2'b01;
    step(1, 1, 16'h0f0f);
    chk(data_out, 16'hff77);
    chk(data_out_en, 16'h00ff);
    {clk_en, low_half_output_enable_n} = 2'b10;
  endtask
  // Supply loss turns every driver off even with an enable low.
  task automatic t_power;
    power_good = 0;
    @(posedge clk) #1;
    chk(data_out_en, 16'h0000);
    {low_half_output_enable_n, high_half_output_enable_n} = 2'b11;
    @(posedge clk) #1;
    power_good = 1;
    @(posedge clk) #1;
    chk(data_out_en, 16'h0000);
    chk(data_out, 16'hff77);
  endtask
  task automatic complete_run;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_halves();
    t_hiz();
    t_hold();
    t_keep();
    t_freeze();
    t_power();
    complete_run();
  end
endmodule
`default_nettype wire
